// ==== core/spc_core.sv ====
/*
  Serial peripheral port core: master/slave byte shifter, status flags,
  receive FIFO. Control and status are plain ports; pins sampled twice.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_core (
  input wire logic mclk, // CPU clock, 40 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic ctrlWrite, // Pulse: load control bits
  input wire logic enableIn, // Port enable value
  input wire logic masterIn, // Master select value
  input wire logic cpolIn, // Clock polarity
  input wire logic cphaIn, // Clock phase
  input wire logic [2:0] rateIn, // Master rate select 0..5
  input wire logic ssSoftMode, // Select from software level
  input wire logic ssSoftLevel, // Software select level
  input wire logic statusRead, // Pulse: status register read
  input wire logic dataWrite, // Pulse: data register write
  input wire logic [7:0] dataIn, // Byte to send
  input wire logic dataRead, // Pulse: pop received byte
  output logic [7:0] dataOut, // Oldest received byte
  output logic rxValid, // Received byte waiting
  output logic enabled, // Enable bit state
  output logic master, // Master bit state
  output logic endFlag, // end_of_transfer_flag
  output logic collisionFlag, // write_collision_flag
  output logic faultFlag, // master_fault_flag
  output logic overrunFlag, // overrun_flag
  output logic busy, // Transfer under way
  input wire logic sckIn, // SCK pin level
  output logic sckOut, // SCK drive value
  output logic sckOen, // SCK enable, low drives
  input wire logic mosiIn, // MOSI pin level
  output logic mosiOut, // MOSI drive value
  output logic mosiOen, // MOSI enable, low drives
  input wire logic misoIn, // MISO pin level
  output logic misoOut, // MISO drive value
  output logic misoOen, // MISO enable, low drives
  input wire logic ssIn // SS pin level, active low
);
  spc_pkg::spc_state_t state, next_state;
  logic [1:0] sckSync, mosiSync, misoSync, ssSync;
  logic sckPrev, next_sckPrev;
  logic [7:0] shiftReg, next_shiftReg;
  logic [2:0] bitCnt, next_bitCnt;
  logic [7:0] divCnt, next_divCnt;
  logic sckInt, next_sckInt;
  logic halfDone, next_halfDone;
  logic statusSeen, next_statusSeen;
  logic next_enabled, next_master, next_endFlag, next_collisionFlag;
  logic next_faultFlag, next_overrunFlag;
  logic next_sckOut, next_sckOen, next_mosiOut, next_mosiOen, next_misoOut, next_misoOen;
  logic next_busy;
  logic [7:0] rxByte, next_rxByte;
  logic rxPush, next_rxPush;
  logic [7:0] divide;
  logic ssActive, sckRise, sckFall, leadEdge, trailEdge, inBit;
  logic fifoValid, fifoFull, fifoEmpty;
  logic [7:0] fifoData;
  spc_fifo_if rxIf ();

  // Two-flop synchronisers on every pin input
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sckSync <= 2'b00;
      mosiSync <= 2'b00;
      misoSync <= 2'b00;
      ssSync <= 2'b11;
    end
    else
    begin
      sckSync <= {sckSync[0], sckIn};
      mosiSync <= {mosiSync[0], mosiIn};
      misoSync <= {misoSync[0], misoIn};
      ssSync <= {ssSync[0], ssIn};
    end
  end

  // Rate select to divider
  always_comb
  begin
    case (rateIn)
      3'h0: divide = spc_pkg::RateDiv0;
      3'h1: divide = spc_pkg::RateDiv1;
      3'h2: divide = spc_pkg::RateDiv2;
      3'h3: divide = spc_pkg::RateDiv3;
      3'h4: divide = spc_pkg::RateDiv4;
      default: divide = spc_pkg::RateDiv5;
    endcase
  end

  // Select, edges and data source
  always_comb
  begin
    ssActive = ssSoftMode ? !ssSoftLevel : !ssSync[1];
    sckRise = sckSync[1] && !sckPrev;
    sckFall = !sckSync[1] && sckPrev;
    // Leading edge leaves idle level; trailing returns to it
    leadEdge = cpolIn ? sckFall : sckRise;
    trailEdge = cpolIn ? sckRise : sckFall;
    inBit = master ? misoSync[1] : mosiSync[1];
  end

  // Main sequencer, flags and pins
  always_comb
  begin
    next_state = state;
    next_sckPrev = sckSync[1];
    next_shiftReg = shiftReg;
    next_bitCnt = bitCnt;
    next_divCnt = divCnt;
    next_sckInt = sckInt;
    next_halfDone = halfDone;
    next_statusSeen = statusSeen;
    next_enabled = enabled;
    next_master = master;
    next_endFlag = endFlag;
    next_collisionFlag = collisionFlag;
    next_faultFlag = faultFlag;
    next_overrunFlag = overrunFlag;
    next_rxByte = rxByte;
    next_rxPush = 1'b0;
    // Status read arms flag clearing; overrun and collision clear at once
    if (statusRead)
    begin
      next_overrunFlag = 1'b0;
      next_collisionFlag = 1'b0;
      if (endFlag || faultFlag)
        next_statusSeen = 1'b1;
    end
    if (ctrlWrite)
    begin
      // Fault clears on control write after status read
      if (faultFlag && statusSeen)
        next_faultFlag = 1'b0;
      if (!faultFlag || statusSeen)
      begin
        next_enabled = enableIn;
        next_master = masterIn;
      end
    end
    // Data access after status read clears end flag
    if ((dataRead || dataWrite) && endFlag && statusSeen)
    begin
      next_endFlag = 1'b0;
      next_statusSeen = 1'b0;
    end
    case (state)
      spc_pkg::SpcIdle:
      begin
        next_sckInt = cpolIn;
        next_divCnt = 8'h00;
        next_halfDone = 1'b0;
        next_bitCnt = spc_pkg::BitsPerByte;
        // Write blocked while end flag awaits status read
        if (dataWrite && enabled && !(endFlag && !statusSeen))
          next_shiftReg = dataIn;
        if (master && enabled && dataWrite && !(endFlag && !statusSeen))
          next_state = spc_pkg::SpcShift;
        else if (!master && enabled && ssActive && leadEdge)
        begin
          // Slave starts only on the master's clock
          next_state = spc_pkg::SpcShift;
          if (!cphaIn)
          begin
            // First bit taken here, seven more follow in the shift state
            next_shiftReg = {shiftReg[6:0], inBit};
            next_bitCnt = 3'(spc_pkg::BitsPerByte - 3'h1);
            next_halfDone = 1'b1;
          end
        end
      end
      spc_pkg::SpcShift:
      begin
        if (dataWrite)
          next_collisionFlag = 1'b1;
        if (master)
        begin
          // Half-period divider produces SCK
          if (divCnt == 8'((divide >> 1) - 8'h01))
          begin
            next_divCnt = 8'h00;
            // Shift on the launching edge: synchronised MISO has settled by then
            if (halfDone)
            begin
              // Phase 1 tail: last bit taken half a period after the final edge
              next_shiftReg = {shiftReg[6:0], inBit};
              next_state = spc_pkg::SpcDone;
            end
            else if (sckInt == cpolIn)
            begin
              // Leading edge: phase 1 launches the next bit
              next_sckInt = !sckInt;
              if (cphaIn && bitCnt != spc_pkg::BitsPerByte)
                next_shiftReg = {shiftReg[6:0], inBit};
            end
            else
            begin
              // Trailing edge: phase 0 launches the next bit
              next_sckInt = !sckInt;
              if (!cphaIn)
                next_shiftReg = {shiftReg[6:0], inBit};
              if (bitCnt == 3'h0)
              begin
                if (cphaIn)
                  next_halfDone = 1'b1;
                else
                  next_state = spc_pkg::SpcDone;
              end
              else
                next_bitCnt = 3'(bitCnt - 3'h1);
            end
          end
          else
            next_divCnt = 8'(divCnt + 8'h01);
        end
        else if (!ssActive && !cphaIn)
          next_state = spc_pkg::SpcIdle; // Aborted by select
        else if (cphaIn ? trailEdge : leadEdge)
        begin
          next_shiftReg = {shiftReg[6:0], inBit};
          if (bitCnt == 3'h0)
            next_state = spc_pkg::SpcDone;
          else
            next_bitCnt = 3'(bitCnt - 3'h1);
        end
        else if (cphaIn && leadEdge)
          next_halfDone = 1'b1;
      end
      default:
      begin
        // Byte complete: flag it, queue it, note overrun
        next_rxByte = shiftReg;
        if (dataWrite)
          next_collisionFlag = 1'b1;
        next_rxPush = 1'b1;
        if (endFlag && !(next_endFlag == 1'b0))
          next_overrunFlag = 1'b1;
        next_endFlag = 1'b1;
        next_statusSeen = 1'b0;
        next_sckInt = cpolIn;
        next_state = spc_pkg::SpcIdle;
      end
    endcase
    // SS pin low while master, outside soft select mode: fault, drop to disabled slave
    if (master && enabled && !ssSoftMode && !ssSync[1])
    begin
      next_faultFlag = 1'b1;
      next_statusSeen = 1'b0;
      next_enabled = 1'b0;
      next_master = 1'b0;
      next_state = spc_pkg::SpcIdle;
    end
    else if (!enabled)
      next_state = spc_pkg::SpcIdle;
    // Pin drivers, enable low means driven
    next_sckOen = !(enabled && master);
    next_sckOut = (state == spc_pkg::SpcShift) ? next_sckInt : cpolIn;
    next_mosiOen = !(enabled && master);
    next_mosiOut = next_shiftReg[7];
    next_misoOen = !(enabled && !master && ssActive);
    next_misoOut = next_shiftReg[7];
    next_busy = (next_state != spc_pkg::SpcIdle);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      // Disabled slave, flags clear, pins released
      state <= spc_pkg::SpcIdle;
      sckPrev <= 1'b0;
      shiftReg <= spc_pkg::DataReset;
      bitCnt <= spc_pkg::BitsPerByte;
      divCnt <= 8'h00;
      sckInt <= 1'b0;
      halfDone <= 1'b0;
      statusSeen <= 1'b0;
      enabled <= 1'b0;
      master <= 1'b0;
      endFlag <= 1'b0;
      collisionFlag <= 1'b0;
      faultFlag <= 1'b0;
      overrunFlag <= 1'b0;
      rxByte <= spc_pkg::DataReset;
      rxPush <= 1'b0;
      sckOut <= 1'b0;
      sckOen <= 1'b1;
      mosiOut <= 1'b0;
      mosiOen <= 1'b1;
      misoOut <= 1'b0;
      misoOen <= 1'b1;
      busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      sckPrev <= next_sckPrev;
      shiftReg <= next_shiftReg;
      bitCnt <= next_bitCnt;
      divCnt <= next_divCnt;
      sckInt <= next_sckInt;
      halfDone <= next_halfDone;
      statusSeen <= next_statusSeen;
      enabled <= next_enabled;
      master <= next_master;
      endFlag <= next_endFlag;
      collisionFlag <= next_collisionFlag;
      faultFlag <= next_faultFlag;
      overrunFlag <= next_overrunFlag;
      rxByte <= next_rxByte;
      rxPush <= next_rxPush;
      sckOut <= next_sckOut;
      sckOen <= next_sckOen;
      mosiOut <= next_mosiOut;
      mosiOen <= next_mosiOen;
      misoOut <= next_misoOut;
      misoOen <= next_misoOen;
      busy <= next_busy;
    end
  end

  // Received bytes queue; oldest is kept when full
  assign rxIf.valid = rxPush;
  assign rxIf.data = rxByte;
  spc_fifo #(.Width(spc_pkg::DataWidth), .Depth(spc_pkg::FifoDepth)) rxFifo (
    .mclk(mclk),
    .rstn(rstn),
    .in(rxIf),
    .outValid(fifoValid),
    .outReady(dataRead),
    .outData(fifoData),
    .full(fifoFull),
    .empty(fifoEmpty)
  );

  // Registered read side
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dataOut <= spc_pkg::DataReset;
      rxValid <= 1'b0;
    end
    else
    begin
      dataOut <= fifoData;
      rxValid <= fifoValid && !dataRead;
    end
  end
endmodule : spc_core
`default_nettype wire

// ==== core/spc_pkg.sv ====
/*
  Constants and types shared by the serial port core.
  Assumes a single 40 MHz clock and no register bus.
*/
package spc_pkg;
  localparam int DataWidth = 8;
  localparam int FifoDepth = 32;
  localparam int ClkMhz = 40;
  // Master divider per rate select: CPU clock divided by these
  localparam logic [7:0] RateDiv0 = 8'h04;
  localparam logic [7:0] RateDiv1 = 8'h08;
  localparam logic [7:0] RateDiv2 = 8'h10;
  localparam logic [7:0] RateDiv3 = 8'h20;
  localparam logic [7:0] RateDiv4 = 8'h40;
  localparam logic [7:0] RateDiv5 = 8'h80;
  localparam logic [2:0] BitsPerByte = 3'h7;
  localparam logic [7:0] DataReset = 8'h00;
  typedef enum logic [1:0] {SpcIdle, SpcShift, SpcDone} spc_state_t;
endpackage : spc_pkg

// ==== core/spc_fifo_if.sv ====
/*
  Stream carrier between the core and its receive FIFO.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface spc_fifo_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : spc_fifo_if
`default_nettype wire

// ==== core/spc_fifo.sv ====
/*
  Parameterised flop FIFO with valid/ready on both sides.
  Assumes one clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_fifo #(
  parameter int Width = 8,
  parameter int Depth = 32
) (
  input wire logic mclk, // Clock
  input wire logic rstn, // Async reset, active low
  spc_fifo_if.snk in, // Fill side
  output logic outValid, // Word available
  input wire logic outReady, // Drain side takes word
  output logic [Width-1:0] outData, // Head word
  output logic full, // No room
  output logic empty // No word
);
  localparam int Aw = $clog2(Depth);
  logic [Width-1:0] mem [Depth];
  logic [Aw-1:0] wrPtr, rdPtr;
  logic [Aw:0] count;
  logic [Aw-1:0] next_wrPtr, next_rdPtr;
  logic [Aw:0] next_count;
  logic doWr, doRd;

  // Pointer and count updates
  always_comb
  begin
    doWr = in.valid && !full;
    doRd = outReady && !empty;
    next_wrPtr = doWr ? Aw'(wrPtr + 1'b1) : wrPtr;
    next_rdPtr = doRd ? Aw'(rdPtr + 1'b1) : rdPtr;
    next_count = count;
    if (doWr && !doRd)
      next_count = (Aw+1)'(count + 1'b1);
    else if (doRd && !doWr)
      next_count = (Aw+1)'(count - 1'b1);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // Storage
  always_ff @(posedge mclk)
  begin
    if (doWr)
      mem[wrPtr] <= in.data;
  end

  assign full = (count == (Aw+1)'(Depth));
  assign empty = (count == '0);
  assign in.ready = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr];
endmodule : spc_fifo
`default_nettype wire

// ==== verif/spc_core_sva.sv ====
/* Port assertions for the serial port core.
   Assumes one clock domain; bound to every spc_core. */
`timescale 1ns/1ps
`default_nettype none
module spc_core_sva (
  input wire logic mclk, // Clock
  input wire logic rstn, // Reset
  input wire logic statusRead, // Status read
  input wire logic dataWrite, // Data write
  input wire logic ssSoftMode, // Soft select
  input wire logic ssIn, // Select pin
  input wire logic [2:0] rateIn, // Rate
  input wire logic enabled, // Enable
  input wire logic master, // Master
  input wire logic endFlag, // End flag
  input wire logic collisionFlag, // Collision
  input wire logic faultFlag, // Fault
  input wire logic overrunFlag, // Overrun
  input wire logic busy, // Busy
  input wire logic sckOut, // SCK value
  input wire logic sckOen, // SCK enable
  input wire logic mosiOen, // MOSI enable
  input wire logic misoOen // MISO enable
);
  logic seen, prevSck, togSeen;
  logic [7:0] togCnt;
  logic [7:0] half;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // Expected SCK half period in clocks
  assign half = (rateIn > 3'h5) ? 8'h40 : 8'h02 << rateIn;
  // Status-read and SCK spacing trackers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      seen <= 1'h0;
      prevSck <= 1'h0;
      togSeen <= 1'h0;
      togCnt <= 8'h00;
    end
    else
    begin
      seen <= endFlag && (seen || statusRead);
      prevSck <= sckOut;
      togSeen <= busy && (togSeen || sckOut != prevSck);
      togCnt <= (sckOut != prevSck) ? 8'h01 : togCnt + 8'h01;
    end
  end
  a_reset_quiet: assert property ($rose(rstn) |-> !enabled && !master && !endFlag && !faultFlag && !overrunFlag
    && !collisionFlag && sckOen && mosiOen && misoOen) else $error("state after reset wrong");
  a_idle_released: assert property (!enabled [*2] |-> sckOen && mosiOen && misoOen)
    else $error("pins driven while disabled");
  a_master_drives: assert property ((enabled && master) [*2] |-> !sckOen && !mosiOen)
    else $error("master not driving");
  a_slave_listens: assert property ((enabled && !master) [*2] |-> sckOen && mosiOen)
    else $error("slave drives clock");
  a_fault_drop: assert property ($fell(ssIn) && enabled && master && !ssSoftMode
    |-> ##[1:4] (faultFlag && !enabled && !master)) else $error("no mode fault");
  a_collide_flag: assert property (busy && dataWrite |-> ##[1:2] collisionFlag)
    else $error("no collision flag");
  a_overrun_clear: assert property (statusRead && !busy |=> !overrunFlag)
    else $error("overrun not cleared");
  a_end_blocks: assert property (endFlag && !seen && !statusRead && dataWrite && !busy |=> !busy)
    else $error("write not blocked");
  a_sck_half: assert property (master && busy && togSeen && sckOut != prevSck |-> togCnt == half)
    else $error("clock half period wrong");
  a_slave_waits: assert property ((!master && ssIn && !ssSoftMode && !busy) [*3] |=> !busy)
    else $error("slave started alone");
  c_master_done: cover property (master && $rose(endFlag));
  c_collision: cover property ($rose(collisionFlag));
  c_fault: cover property ($rose(faultFlag));
  c_overrun: cover property ($rose(overrunFlag));
endmodule : spc_core_sva
bind spc_core spc_core_sva chk (.mclk, .rstn, .statusRead, .dataWrite, .ssSoftMode, .ssIn, .rateIn, .enabled,
  .master, .endFlag, .collisionFlag, .faultFlag, .overrunFlag, .busy, .sckOut, .sckOen, .mosiOen, .misoOen);
`default_nettype wire

// ==== verif/spc_peer.sv ====
/* Far-side serial device: slave on its select, master by task.
   Assumes the bench resolves shared lines with pulls. */
`timescale 1ns/1ps
`default_nettype none
module spc_peer (
  input wire logic mclk, // Timing for master role
  input wire logic cpol, // Polarity
  input wire logic cpha, // Phase
  input wire logic selN, // Select, active low
  input wire logic sck, // Clock line
  input wire logic mosi, // MOSI line
  input wire logic miso, // MISO line
  input wire logic [7:0] txByte, // Byte sent as slave
  output logic [7:0] rxByte, // Byte taken as slave
  output logic sckDrv, // Clock drive
  output logic sckEn, // High drives clock
  output logic mosiDrv, // MOSI drive
  output logic mosiEn, // High drives MOSI
  output logic misoDrv, // MISO drive
  output logic misoEn // High drives MISO
);
  int nShift;
  int k;
  wire logic sampleClk;
  // Capture edge rises, shift edge falls; same mode as the core
  assign sampleClk = sck ^ cpol ^ cpha;
  assign k = nShift - int'(cpha);
  assign misoDrv = (k >= 0 && k < 8) ? txByte[7-k] : 1'h1;
  assign misoEn = !selN;
  initial
  begin
    {rxByte, sckDrv, sckEn, mosiDrv, mosiEn} = 12'h020;
    nShift = 0;
  end
  // Slave shifting
  always @(negedge selN) nShift = 0;
  always @(posedge sampleClk) if (!selN) rxByte = {rxByte[6:0], mosi};
  always @(negedge sampleClk) if (!selN) nShift = nShift + 1;
  // Master frame, clock still outside it
  task automatic xfer(input logic [7:0] tx, input int half, output logic [7:0] got);
    got = 8'h00;
    sckDrv = cpol;
    sckEn = 1'h1;
    mosiEn = 1'h1;
    repeat (2 * half) @(posedge mclk);
    for (int i = 7; i >= 0; i--)
    begin
      #1 if (!cpha) mosiDrv = tx[i];
      repeat (half) @(posedge mclk);
      #1 sckDrv = !sckDrv;
      if (cpha) mosiDrv = tx[i];
      else got[i] = miso;
      repeat (half) @(posedge mclk);
      #1 sckDrv = !sckDrv;
      if (cpha) got[i] = miso;
    end
    repeat (half) @(posedge mclk);
    #1 sckEn = 1'h0;
    mosiEn = 1'h0;
  endtask : xfer
endmodule : spc_peer
`default_nettype wire

// ==== verif/spi_serial_port_core_test.sv ====
/* Self-checking bench for the serial port core.
   Assumes the peer model and bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module spi_serial_port_core_test;
  logic mclk, rstn, ctrlWrite, enableIn, masterIn, cpolIn, cphaIn, ssSoftMode, ssSoftLevel, statusRead;
  logic dataWrite, dataRead, ssIn, peerSelN, rxValid, enabled, master, endFlag, collisionFlag, faultFlag;
  logic overrunFlag, busy, sckOut, sckOen, mosiOut, mosiOen, misoOut, misoOen;
  logic sckDrv, sckEn, mosiDrv, mosiEn, misoDrv, misoEn;
  logic [2:0] rateIn;
  logic [7:0] dataIn, dataOut, txByte, rxByte, got, tx, pw;
  logic [31:0] seed;
  logic [7:0] rxq[$];
  wire logic sck, mosi, miso;
  int n_fail, n_tests, cycles;
  // Lines resolved, SCK pulled to idle level, data pulled up
  assign sck = !sckOen ? sckOut : (sckEn ? sckDrv : cpolIn);
  assign mosi = !mosiOen ? mosiOut : (mosiEn ? mosiDrv : 1'h1);
  assign miso = !misoOen ? misoOut : (misoEn ? misoDrv : 1'h1);
  spc_core uut (.mclk, .rstn, .ctrlWrite, .enableIn, .masterIn, .cpolIn, .cphaIn, .rateIn, .ssSoftMode,
    .ssSoftLevel, .statusRead, .dataWrite, .dataIn, .dataRead, .dataOut, .rxValid, .enabled, .master, .endFlag,
    .collisionFlag, .faultFlag, .overrunFlag, .busy, .sckIn(sck), .sckOut, .sckOen, .mosiIn(mosi), .mosiOut,
    .mosiOen, .misoIn(miso), .misoOut, .misoOen, .ssIn);
  spc_peer peer (.mclk, .cpol(cpolIn), .cpha(cphaIn), .selN(peerSelN), .sck, .mosi, .miso, .txByte, .rxByte,
    .sckDrv, .sckEn, .mosiDrv, .mosiEn, .misoDrv, .misoEn);
  // Clock and hang guard
  always #12.5 mclk = !mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      n_fail++;
      stop_test();
    end
  end
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd8
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask : pulse
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic setCtrl(input logic en, input logic ms);
    enableIn = en;
    masterIn = ms;
    pulse(ctrlWrite);
    cyc(1);
  endtask : setCtrl
  // One master byte, optional collision, then blocked write and flag clearing
  task automatic mxfer(input logic [7:0] t, input logic [7:0] p, input logic coll);
    int n;
    txByte = p;
    dataIn = t;
    pulse(dataWrite);
    cyc(1);
    check(busy, 16'h0001);
    if (coll)
    begin
      dataIn = ~t;
      pulse(dataWrite);
      cyc(1);
      check(collisionFlag, 16'h0001);
    end
    n = 0;
    while (n < 5000 && !(endFlag === 1'h1 && rxValid === 1'h1))
    begin
      cyc(1);
      n++;
    end
    check(rxByte, t);
    check(dataOut, p);
    pulse(dataWrite);
    cyc(2);
    check(busy, 16'h0000);
    pulse(statusRead);
    pulse(dataRead);
    cyc(2);
    check({endFlag, collisionFlag, rxValid}, 16'h0000);
  endtask : mxfer
  initial
  begin
    {mclk, rstn, ctrlWrite, enableIn, masterIn, cpolIn, cphaIn, ssSoftMode, ssSoftLevel} = 9'h000;
    {statusRead, dataWrite, dataRead, rateIn, dataIn, txByte} = 22'h00_0000;
    {ssIn, peerSelN} = 2'h3;
    seed = 32'h0000_9278;
    repeat (4) @(posedge mclk);
    #1 rstn = 1'h1;
    cyc(1);
    check({enabled, master, endFlag, collisionFlag, faultFlag, overrunFlag, busy, sckOen, mosiOen, misoOen},
      16'h0007);
    // Master bytes over every mode and rate
    for (int i = 0; i < 6; i++)
    begin
      setCtrl(1'h0, 1'h0);
      {cphaIn, cpolIn} = 2'(i);
      rateIn = 3'(i);
      setCtrl(1'h1, 1'h1);
      check({enabled, master}, 16'h0003);
      peerSelN = 1'h0;
      mxfer(rnd8(), rnd8(), i == 2);
      peerSelN = 1'h1;
    end
    // Select pulled low under a master
    ssIn = 1'h0;
    cyc(6);
    check({faultFlag, enabled, master}, 16'h0004);
    ssIn = 1'h1;
    setCtrl(1'h1, 1'h1);
    check(enabled, 16'h0000);
    pulse(statusRead);
    setCtrl(1'h1, 1'h0);
    check({faultFlag, enabled, master}, 16'h0002);
    // Unselected slave ignores a frame
    peer.xfer(8'hA5, 6, got);
    cyc(3);
    check({rxValid, endFlag, busy}, 16'h0000);
    // Slave bytes until the receive buffer refuses
    for (int i = 0; i < 33; i++)
    begin
      tx = rnd8();
      ssSoftMode = i[0];
      cphaIn = i[0];
      ssIn = 1'h1;
      pulse(statusRead);
      dataIn = tx;
      pulse(dataWrite);
      ssIn = i[0];
      cyc(3);
      pw = rnd8();
      peer.xfer(pw, 6, got);
      ssIn = 1'h1;
      cyc(3);
      check(got, tx);
      if (i < 32) rxq.push_back(pw);
    end
    // Drain in order
    foreach (rxq[j])
    begin
      check({rxValid, dataOut}, {8'h01, rxq[j]});
      pulse(dataRead);
      cyc(2);
    end
    check(rxValid, 16'h0000);
    // Two frames without clearing the end flag
    pulse(statusRead);
    pulse(dataRead);
    cphaIn = 1'h1;
    ssSoftMode = 1'h1;
    repeat (2) peer.xfer(rnd8(), 6, got);
    cyc(3);
    check(overrunFlag, 16'h0001);
    pulse(statusRead);
    cyc(2);
    check(overrunFlag, 16'h0000);
    stop_test();
  end
endmodule : spi_serial_port_core_test
`default_nettype wire
